// *** core/acp_config_port.sv ***
// Purpose: Serial configuration port: shift register, holding word, field decode,
//          serial output and check pulse detection on the shared pin.
// Assumes: Host serial clock, select and data are asynchronous and slow
//          (bench period 800 ns) against core_clk at 10 MHz.
// Notes:   All pin inputs pass two flip-flops; edges are found on synced levels.
`timescale 1ns/1ps

// Summary of operation
// R1 - Sixteen-bit shift register filled from the serial input pin.
// R2 - Bits moving through the shift register appear on the shared output pin.
// R3 - Host sends all sixteen bits per frame; shorter frames misprogram.
// R4 - Falling select edge enables the shift register.
// R5 - Host keeps serial clock high at both select edges.
// R6 - One input bit captured per rising serial clock edge while selected.
// R7 - Rising select edge copies shift register into the holding word.
// R8 - Bit 15 picks pH (0) or temperature (1) measurement.
// R9 - Bit 14 routes current to thermal pin (0) or reference pin (1).
// R10 - Bits 13:12 set current 100 uA, 200 uA, 1 mA or 2 mA.
// R11 - Bit 11 sets amplifier gain 5 (0) or 10 (1).
// R12 - Bits 10:8 pick common level in eighths of the reference.
// R13 - In pH mode bit 7 refers output to common pin (0) or ground.
// R14 - Temperature mode always refers the output to ground.
// R15 - Temperature mode puts amplified resistor voltage on the main output.
// R16 - Bit 6 enables check pulses on the shared pin.
// R17 - Host check pulses last at least 100 ns.
// R18 - A check pulse steps the common level by five percent of reference.
// R19 - Host writes zeros to bits 5:0; device ignores them.
// R20 - Holding word reads zero until the first frame commits.
module acp_config_port
    import acp_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,

    // Serial link pins, asynchronous
    input  wire logic        sclk,
    input  wire logic        select_bar,
    input  wire logic        serial_in,

    // Shared serial output and check pulse pin
    input  wire logic        serial_out_pulse_pin_i,
    output logic             serial_out_pulse_pin_o,
    output logic             serial_out_pulse_pin_oe,

    // Holding word and frame status
    output logic [15:0]      configuration_word,
    output logic             frame_short,

    // Decoded analog controls
    output logic             mode_select,
    output logic             current_route,
    output logic             thermal_resistor_pin_en,
    output logic [1:0]       current_code,
    output logic [11:0]      current_ua,
    output logic             gain_select,
    output logic [3:0]       gain_value,
    output logic [2:0]       common_level,
    output logic [3:0]       common_eighths,
    output logic             output_reference,
    output logic             output_to_ground,
    output logic             vout_from_amp,
    output logic             check_pulse_enable,

    // Check pulse step applied to the common level
    output logic             common_step_active,
    output logic             common_step_up,
    output logic [3:0]       common_step_pct
);

    // Synchronised pin levels
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic              sclk_s;
    logic              sel_b_s;
    logic              din_s;
    logic              pulse_s;

    // Edge history
    logic              sclk_prev_q;
    logic              sclk_prev_d;
    logic              sel_prev_q;
    logic              sel_prev_d;
    logic              sclk_rise;
    logic              sel_fall;
    logic              sel_rise;

    // Link state
    acp_state_t        state_q;
    acp_state_t        state_d;
    logic [CFG_W-1:0]  shift_q;
    logic [CFG_W-1:0]  shift_d;
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    logic [CFG_W-1:0]  cfg_q;
    logic [CFG_W-1:0]  cfg_d;
    logic              short_q;
    logic              short_d;
    logic              sout_q;
    logic              sout_d;

    // Check pulse state
    logic [3:0]        ton_q;
    logic [3:0]        ton_d;
    logic              step_q;
    logic              step_d;
    logic [3:0]        pct_q;
    logic [3:0]        pct_d;

    // Registered lookups; data outputs come from flip-flops, never from a
    // decode that settles after the holding word
    logic              to_gnd_q;
    logic              to_gnd_d;
    logic [3:0]        gain_val_q;
    logic [3:0]        gain_val_d;
    logic [11:0]       cur_ua_q;
    logic [11:0]       cur_ua_d;
    logic [3:0]        eighths_q;
    logic [3:0]        eighths_d;

    // Pin bundle into the synchroniser
    // One synchroniser for all four pins; each bit is an independent level
    assign pins_async = {serial_out_pulse_pin_i, serial_in, select_bar, sclk};

    acp_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign sclk_s  = pins_sync[0];
    assign sel_b_s = pins_sync[1];
    assign din_s   = pins_sync[2];
    assign pulse_s = pins_sync[3];

    // Edges found on synced levels only, never on the first stage
    assign sclk_prev_d = sclk_s;
    assign sel_prev_d  = sel_b_s;
    assign sclk_rise   = sclk_s & ~sclk_prev_q;
    assign sel_fall    = ~sel_b_s & sel_prev_q;
    assign sel_rise    = sel_b_s & ~sel_prev_q;

    // Link next state: shift on clock rises, commit on select rise
    // A select rise outranks a clock rise seen in the same cycle; that bit is dropped
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        count_d = count_q;
        cfg_d   = cfg_q;
        short_d = short_q;
        sout_d  = sout_q;
        unique case (state_q)
            ACP_IDLE: begin
                if (sel_fall) begin // R4
                    state_d = ACP_SHIFT;
                    count_d = '0;
                end
            end
            ACP_SHIFT: begin
                if (sel_rise) begin
                    // Reserved bits are dropped so decode never sees them
                    cfg_d   = shift_q & CFG_KEEP_MASK; // R7 R19
                    // Short frames still commit; the flag lets software see it
                    short_d = (count_q < FULL_FRAME); // R3
                    state_d = ACP_IDLE;
                end else if (sclk_rise) begin
                    // Shift in at the bottom, oldest bit leaves at the top
                    shift_d = {shift_q[CFG_W-2:0], din_s}; // R1 R6
                    sout_d  = shift_q[CFG_W-1]; // R2
                    if (count_q != FULL_FRAME) begin
                        count_d = count_q + 1'b1;
                    end
                end
            end
        endcase
    end

    // Link registers; holding word clears only at reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= ACP_IDLE;
            shift_q     <= '0;
            count_q     <= '0;
            cfg_q       <= CFG_RESET; // R20
            short_q     <= 1'b0;
            sout_q      <= 1'b0;
            sclk_prev_q <= 1'b0;
            // Edge history clears to the synchroniser's reset level, so the pins
            // settling after reset never look like a select fall
            sel_prev_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            shift_q     <= shift_d;
            count_q     <= count_d;
            cfg_q       <= cfg_d;
            short_q     <= short_d;
            sout_q      <= sout_d;
            sclk_prev_q <= sclk_prev_d;
            sel_prev_q  <= sel_prev_d;
        end
    end

    // Field decode from the holding word
    assign configuration_word = cfg_q;
    assign frame_short        = short_q;
    assign mode_select        = cfg_q[BIT_MODE]; // R8
    assign current_route      = cfg_q[BIT_ROUTE]; // R9
    assign thermal_resistor_pin_en = ~cfg_q[BIT_ROUTE]; // R9
    assign current_code       = cfg_q[CUR_HI:CUR_LO];
    assign gain_select        = cfg_q[BIT_GAIN];
    assign common_level       = cfg_q[CML_HI:CML_LO];
    assign output_reference   = cfg_q[BIT_OUTREF];
    assign check_pulse_enable = cfg_q[BIT_CHECK]; // R16
    assign vout_from_amp      = cfg_q[BIT_MODE]; // R15

    // Lookup next values, decoded from the word about to be held: the outputs
    // then come from flip-flops yet change on the same edge as the holding word
    always_comb begin
        // Temperature mode forces ground reference whatever bit 7 holds
        to_gnd_d   = cfg_d[BIT_MODE] | cfg_d[BIT_OUTREF]; // R13 R14
        gain_val_d = cfg_d[BIT_GAIN] ? GAIN_HIGH : GAIN_LOW; // R11
        unique case (cfg_d[CUR_HI:CUR_LO])
            2'h0:    cur_ua_d = CUR_UA_0; // R10
            2'h1:    cur_ua_d = CUR_UA_1;
            2'h2:    cur_ua_d = CUR_UA_2;
            2'h3:    cur_ua_d = CUR_UA_3;
        endcase
        // Codes 0 and 4 both give half reference
        unique case (cfg_d[CML_HI:CML_LO])
            3'h0:    eighths_d = CML_E0; // R12
            3'h1:    eighths_d = CML_E1;
            3'h2:    eighths_d = CML_E2;
            3'h3:    eighths_d = CML_E3;
            3'h4:    eighths_d = CML_E4;
            3'h5:    eighths_d = CML_E5;
            3'h6:    eighths_d = CML_E6;
            3'h7:    eighths_d = CML_E7;
        endcase
    end

    // Lookup registers; reset values are those of an all-zero holding word
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            to_gnd_q   <= 1'b0;
            gain_val_q <= GAIN_LOW;
            cur_ua_q   <= CUR_UA_0; // R20
            eighths_q  <= CML_E0;
        end else begin
            to_gnd_q   <= to_gnd_d;
            gain_val_q <= gain_val_d;
            cur_ua_q   <= cur_ua_d;
            eighths_q  <= eighths_d;
        end
    end

    // Data outputs straight from flip-flops
    assign output_to_ground   = to_gnd_q;
    assign gain_value         = gain_val_q;
    assign current_ua         = cur_ua_q;
    assign common_eighths     = eighths_q;

    // Check pulse next state: high pulse counted, step held while it lasts
    always_comb begin
        ton_d  = ton_q;
        step_d = 1'b0;
        if (check_pulse_enable && pulse_s) begin
            if (ton_q != CHECK_TON_CYC) begin
                ton_d = ton_q + 1'b1;
            end
            // Glitches shorter than the on time never move the level
            step_d = (ton_q >= CHECK_TON_CYC); // R17 R18
        end else begin
            ton_d = '0;
        end
        // Step size registered together with the step itself
        pct_d = step_d ? STEP_PCT : 4'h0; // R18
    end

    // Check pulse registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ton_q  <= '0;
            step_q <= 1'b0;
            pct_q  <= '0;
        end else begin
            ton_q  <= ton_d;
            step_q <= step_d;
            pct_q  <= pct_d;
        end
    end

    // Step only upward: a high pulse on the pin is the only stimulus seen
    assign common_step_active = step_q; // R18
    assign common_step_up     = step_q;
    assign common_step_pct    = pct_q;

    // Shared pin: driven as serial output unless check pulses are enabled
    assign serial_out_pulse_pin_o  = sout_q; // R2
    assign serial_out_pulse_pin_oe = ~check_pulse_enable; // R16

endmodule : acp_config_port

// *** core/acp_pkg.sv ***
// Purpose: Shared constants for the sensor front end serial configuration port.
// Assumes: core_clk at 10 MHz; host serial clock much slower than core_clk.
// Notes:   Bit positions, reset value, lookup values and timing counts live here.
package acp_pkg;

    // Configuration word layout
    localparam int          CFG_W         = 16;
    localparam int          CNT_W         = 5;
    localparam logic [15:0] CFG_RESET     = 16'h0000;
    localparam logic [15:0] CFG_KEEP_MASK = 16'hffc0;   // Reserved low bits dropped
    localparam int          BIT_MODE      = 15;
    localparam int          BIT_ROUTE     = 14;
    localparam int          CUR_HI        = 13;
    localparam int          CUR_LO        = 12;
    localparam int          BIT_GAIN      = 11;
    localparam int          CML_HI        = 10;
    localparam int          CML_LO        = 8;
    localparam int          BIT_OUTREF    = 7;
    localparam int          BIT_CHECK     = 6;
    localparam logic [4:0]  FULL_FRAME    = 5'h10;      // Sixteen bits per frame

    // Excitation current in microamps, indexed by the two-bit code
    localparam logic [11:0] CUR_UA_0      = 12'h064;    // 100 uA
    localparam logic [11:0] CUR_UA_1      = 12'h0c8;    // 200 uA
    localparam logic [11:0] CUR_UA_2      = 12'h3e8;    // 1 mA
    localparam logic [11:0] CUR_UA_3      = 12'h7d0;    // 2 mA

    // Amplifier gain in V/V
    localparam logic [3:0]  GAIN_LOW      = 4'h5;
    localparam logic [3:0]  GAIN_HIGH     = 4'ha;

    // Common level as eighths of the reference, indexed by the three-bit code
    localparam logic [3:0]  CML_E0        = 4'h4;
    localparam logic [3:0]  CML_E1        = 4'h5;
    localparam logic [3:0]  CML_E2        = 4'h6;
    localparam logic [3:0]  CML_E3        = 4'h7;
    localparam logic [3:0]  CML_E4        = 4'h4;
    localparam logic [3:0]  CML_E5        = 4'h3;
    localparam logic [3:0]  CML_E6        = 4'h2;
    localparam logic [3:0]  CML_E7        = 4'h1;

    // Check pulse step size, percent of reference
    localparam logic [3:0]  STEP_PCT      = 4'h5;

    // Timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          CHECK_TON_NS  = 100;
    localparam int          CHECK_TON_RAW =
        (CHECK_TON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  CHECK_TON_CYC =
        (CHECK_TON_RAW < 1) ? 4'h1 : CHECK_TON_RAW[3:0];
    localparam int          SYNC_W        = 4;

    // Link state
    typedef enum logic [0:0] {
        ACP_IDLE,
        ACP_SHIFT
    } acp_state_t;

endpackage : acp_pkg

// *** core/acp_sync.sv ***
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module acp_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Per-bit stage wiring
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign meta_d[g] = async_in[g];
            assign sync_d[g] = meta_q[g];
        end
    endgenerate

    // Two stages, cleared by reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : acp_sync

// *** dv/acp_config_port_properties.sv ***
// Purpose: Port checks for the serial configuration port
// Assumes: Sees only the top module ports
// Notes:   Decode checks tie outputs to the holding word
`timescale 1ns/1ps
module acp_config_port_properties
    import acp_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Observed ports
    input wire logic        select_bar,
    input wire logic        serial_out_pulse_pin_i,
    input wire logic        serial_out_pulse_pin_oe,
    input wire logic [15:0] configuration_word,
    input wire logic        vout_from_amp,
    input wire logic        output_to_ground,
    input wire logic [11:0] current_ua,
    input wire logic [3:0]  gain_value,
    input wire logic [3:0]  common_eighths,
    input wire logic        check_pulse_enable,
    input wire logic        common_step_active,
    input wire logic [3:0]  common_step_pct
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Word only moves after a select rise, never mid frame
    a_hold_in_frame: assert property ((!select_bar)[*4] |=> $stable(configuration_word))
        else $error("holding word moved inside a frame");
    a_reserved_zero: assert property (configuration_word[5:0] == 6'h00)
        else $error("reserved bits kept");
    a_pin_dir: assert property (serial_out_pulse_pin_oe == !configuration_word[6]
        && check_pulse_enable == configuration_word[6])
        else $error("shared pin direction wrong");
    a_mode_out: assert property (vout_from_amp == configuration_word[15])
        else $error("output source wrong");
    a_out_ground: assert property (output_to_ground
        == (configuration_word[15] | configuration_word[7]))
        else $error("output reference wrong");
    a_gain_map: assert property (gain_value == (configuration_word[11] ? 4'ha : 4'h5))
        else $error("gain wrong");
    a_current_map: assert property (current_ua == (configuration_word[13]
        ? (configuration_word[12] ? 12'h7d0 : 12'h3e8)
        : (configuration_word[12] ? 12'h0c8 : 12'h064)))
        else $error("current wrong");
    // Codes above three count down from one half
    a_common_map: assert property (common_eighths == (configuration_word[10]
        ? 4'h4 - {2'b00, configuration_word[9:8]}
        : 4'h4 + {2'b00, configuration_word[9:8]}))
        else $error("common level wrong");
    a_step_cause: assert property (common_step_active |-> check_pulse_enable
        && $past(serial_out_pulse_pin_i, 3) && common_step_pct == 4'h5)
        else $error("step without pulse");
endmodule : acp_config_port_properties

bind acp_config_port acp_config_port_properties i_acp_config_port_properties (
    .core_clk(core_clk), .rst_b(rst_b), .select_bar(select_bar),
    .serial_out_pulse_pin_i(serial_out_pulse_pin_i),
    .serial_out_pulse_pin_oe(serial_out_pulse_pin_oe),
    .configuration_word(configuration_word), .vout_from_amp(vout_from_amp),
    .output_to_ground(output_to_ground), .current_ua(current_ua), .gain_value(gain_value),
    .common_eighths(common_eighths), .check_pulse_enable(check_pulse_enable),
    .common_step_active(common_step_active), .common_step_pct(common_step_pct));

// *** dv/acp_host_model.sv ***
// Purpose: Host model driving the serial link
// Assumes: Serial clock half period is four core cycles
// Notes:   Drives the shared pin only while the device lets go
`timescale 1ns/1ps
module acp_host_model (
    // Clock
    input  wire logic core_clk,
    // Link pins
    output logic      sclk,
    output logic      select_bar,
    output logic      serial_in,
    // Shared pin
    input  wire logic pin_lvl,
    output logic      pulse_v
);
    // Idle link: clock parked high, deselected
    initial begin
        sclk = 1'b1;
        select_bar = 1'b1;
        serial_in = 1'b0;
        pulse_v = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask : half
    // Sends n bits MSB first; rx gathers what the device echoes
    task automatic frame(input logic [31:0] w, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        select_bar <= 1'b0;
        half();
        for (int k = n - 1; k >= 0; k--) begin
            sclk <= 1'b0;
            serial_in <= w[k];
            half();
            sclk <= 1'b1;
            half();
            rx = {rx[14:0], pin_lvl};
        end
        serial_in <= ~serial_in;  // Data no longer valid once the frame is over
        select_bar <= 1'b1;
        half();
        half();
    endtask : frame
    // Check pulse level on the released shared pin; callers hold it over 100 ns
    task automatic pulse(input logic lvl);
        pulse_v <= lvl;
    endtask : pulse
    // Clock edges while deselected, which the device must ignore
    task automatic idle(input int n);
        repeat (n) begin
            sclk <= 1'b0;
            half();
            sclk <= 1'b1;
            half();
        end
    endtask : idle
endmodule : acp_host_model

// *** dv/test_acp_config_port.sv ***
// Purpose: Self-checking bench for the serial configuration port
// Assumes: Host model supplies link timing
// Notes:   Expected words are built here from the field layout
`timescale 1ns/1ps
module test_acp_config_port;
    import acp_pkg::*;
    logic        core_clk, rst_b, sclk, select_bar, serial_in, pulse_v, pin_lvl, pin_o, pin_oe;
    logic        fshort, to_gnd, th_en, chk_en, step;
    logic        msel, croute, gsel, oref, sup;
    logic [1:0]  ccode;
    logic [2:0]  clvl;
    logic [15:0] cfg, rx, w, prev;
    logic [11:0] cur;
    logic [3:0]  gain, eighths, pct;
    logic [2:0]  c;
    int          errors, checks_done;
    logic [3:0]  e_tab [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h4, 4'h3, 4'h2, 4'h1};
    logic [11:0] c_tab [4] = '{12'h064, 12'h0c8, 12'h3e8, 12'h7d0};
    // Shared pin: device wins while it drives, host otherwise
    assign pin_lvl = pin_oe ? pin_o : pulse_v;
    acp_config_port i_acp_config_port (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
        .select_bar(select_bar), .serial_in(serial_in), .serial_out_pulse_pin_i(pin_lvl),
        .serial_out_pulse_pin_o(pin_o), .serial_out_pulse_pin_oe(pin_oe),
        .configuration_word(cfg), .frame_short(fshort), .mode_select(msel),
        .current_route(croute), .thermal_resistor_pin_en(th_en), .current_code(ccode),
        .current_ua(cur), .gain_select(gsel), .gain_value(gain), .common_level(clvl),
        .common_eighths(eighths), .output_reference(oref), .output_to_ground(to_gnd),
        .vout_from_amp(), .check_pulse_enable(chk_en), .common_step_active(step),
        .common_step_up(sup), .common_step_pct(pct));
    acp_host_model i_acp_host_model (.core_clk(core_clk), .sclk(sclk), .select_bar(select_bar),
        .serial_in(serial_in), .pin_lvl(pin_lvl), .pulse_v(pulse_v));
    always #50 core_clk = ~core_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // Watchdog well beyond the roughly 1850 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        conclude();
    end
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(cfg, 16'h0000, "reset word");
        check(16'(cur), 16'h0064, "reset current");
        // Bit 6 clear keeps the shared pin driven for the echo checks that follow
        prev = 16'hb680;
        i_acp_host_model.frame(32'(prev), 16, rx);
        check(cfg, 16'hb680, "first word");
        // Every code of every field except bit 6, which stays clear, reserved bits set to prove they are dropped
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            w = {c[0], c[1], c[1:0], c[2], c, c[1], 1'b0, 6'h2a};
            i_acp_host_model.frame(32'(w), 16, rx);
            check(rx, prev, "echo");
            check(cfg, w & 16'hffc0, "word");
            check(16'({msel, croute, ccode, gsel, clvl, oref}), 16'(w[15:7]), "fields");
            check(16'(eighths), 16'(e_tab[c]), "common");
            check(16'(cur), 16'(c_tab[c[1:0]]), "current");
            check(16'(gain), c[2] ? 16'h000a : 16'h0005, "gain");
            check(16'(to_gnd), 16'(c[0] | c[1]), "ground");
            check(16'(th_en), 16'(!c[1]), "route");
            prev = w;
        end
        i_acp_host_model.idle(3);
        check(cfg, prev & 16'hffc0, "idle clocks");
        i_acp_host_model.frame(32'h0000_003c, 8, rx);
        check(cfg, {prev[7:0], 8'h3c} & 16'hffc0, "short frame");
        check(16'(fshort), 16'h0001, "short flag");
        i_acp_host_model.frame(32'h0005_a3c7, 20, rx);
        check(cfg, 16'ha3c0, "long frame");
        check(16'(fshort), 16'h0000, "short flag");
        i_acp_host_model.frame(32'h0000_8341, 16, rx);
        check(16'(pin_oe), 16'h0000, "pin released");
        check(16'(chk_en), 16'h0001, "check enabled");
        i_acp_host_model.pulse(1'b1);
        repeat (6) @(posedge core_clk);
        check(16'(step), 16'h0001, "step on");
        check(16'(pct), 16'h0005, "step size");
        check(16'(sup), 16'h0001, "step up");
        i_acp_host_model.pulse(1'b0);
        repeat (5) @(posedge core_clk);
        check(16'(step), 16'h0000, "step off");
        check(16'(pct), 16'h0000, "step size off");
        i_acp_host_model.frame(32'h0, 16, rx);
        // Echo of bit zero leaves the pin high with the check disabled
        check(16'(pin_lvl), 16'h0001, "pin echo");
        repeat (6) @(posedge core_clk);
        check(16'(step), 16'h0000, "no step");
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(cfg, 16'h0000, "second reset");
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule : test_acp_config_port
